// >>> core/adc_seq_pkg.sv
// Purpose: shared constants for the serial converter transfer sequencer
// Assumes: 100 MHz system clock
// Notes: times in ns, counts derived at the clock rate
package adc_seq_pkg;
   localparam int unsigned CLK_PERIOD_NS = 10;
   // select filter: setup plus two internal clock falls
   localparam int unsigned SEL_FILTER_NS = 1425;
   localparam int unsigned SEL_FILTER_CYC = (SEL_FILTER_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int unsigned CONV_NS = 21000;
   localparam int unsigned CONV_CYC = CONV_NS / CLK_PERIOD_NS;
   localparam int unsigned ABORT_NS = 9000;
   localparam int unsigned ABORT_CYC = ABORT_NS / CLK_PERIOD_NS;
   localparam int unsigned EOC_FALL_NS = 70;
   localparam int unsigned EOC_FALL_CYC = (EOC_FALL_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam logic [4:0] XFER_BITS = 5'h0A;
   localparam logic [4:0] ACQ_FIRST = 5'h04;
   localparam logic [4:0] ACQ_LAST = 5'h0A;
   localparam logic [3:0] ADDR_TEST_MID = 4'hB;
   localparam logic [3:0] ADDR_TEST_ZERO = 4'hC;
   localparam logic [3:0] ADDR_TEST_FULL = 4'hD;
   localparam logic [9:0] CODE_MID = 10'h200;
   localparam logic [9:0] CODE_ZERO = 10'h000;
   localparam logic [9:0] CODE_FULL = 10'h3FF;
   localparam logic [9:0] RESULT_RST = 10'h000;
   typedef enum logic [1:0] {
      ST_IDLE = 2'b00,
      ST_SHIFT = 2'b01,
      ST_CONV = 2'b10
   } seq_state_t;
endpackage : adc_seq_pkg

// >>> core/sel_filter.sv
// Purpose: synchronise and debounce the active-low select pin
// Assumes: pin is asynchronous to clk
// Notes: a level is accepted only once stable for the filter time
`timescale 1ns/1ns
module sel_filter
   import adc_seq_pkg::*;
(
   // clock and reset
   input wire logic clk,
   input wire logic srst,
   input wire logic ce,
   // pin and filtered level
   input wire logic sel_n_pin,
   output logic sel_n_filt
);
   typedef struct packed {
      logic s1;
      logic s2;
      logic filt;
      logic [8:0] cnt;
   } flt_t;
   flt_t q, d;
   localparam logic [8:0] FCYC = 9'(SEL_FILTER_CYC);

   always_comb begin
      d = q;
      d.s1 = sel_n_pin;
      d.s2 = q.s1;
      if (q.s2 == q.filt) begin
         d.cnt = 9'h000;
      end else if (q.cnt == FCYC - 9'h001) begin
         d.filt = q.s2;
         d.cnt = 9'h000;
      end else begin
         d.cnt = q.cnt + 9'h001;
      end
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         q <= '{s1: 1'b1, s2: 1'b1, filt: 1'b1, cnt: 9'h000};
      end else if (ce) begin
         q <= d;
      end
   end

   assign sel_n_filt = q.filt;
endmodule : sel_filter

// >>> core/adc_seq.sv
// Purpose: serial transfer sequencer of a 10-bit converter
// Assumes: host shift clock far slower than clk; sample value given on a port
// Notes: conversion time is counted, analog value taken from sample_code
`timescale 1ns/1ns
module adc_seq
   import adc_seq_pkg::*;
#(
   parameter int unsigned CONV_CYCLES = CONV_CYC,
   parameter int unsigned ABORT_CYCLES = ABORT_CYC
) (
   // clock and reset
   input wire logic clk,
   input wire logic srst,
   input wire logic ce,
   // host serial pins
   input wire logic sel_n,
   input wire logic sclk,
   input wire logic addr_in,
   output logic data_out,
   output logic data_oe,
   output logic eoc,
   // analog side
   input wire logic [9:0] sample_code,
   output logic [3:0] channel,
   output logic sampling
);
   typedef struct packed {
      seq_state_t st;
      logic ck1;
      logic ck2;
      logic ck3;
      logic ad1;
      logic ad2;
      logic sel_p;
      logic [4:0] bits;
      logic [3:0] addr_sh;
      logic [3:0] chan;
      logic [9:0] out_sh;
      logic [9:0] result;
      logic [14:0] cnt;
      logic [14:0] since10;
      logic eoc;
      logic samp;
      logic dout;
   } seq_t;
   seq_t q, d;
   logic sel_f;
   logic rise, fall;
   localparam logic [14:0] CONV_N = 15'(CONV_CYCLES);
   localparam logic [14:0] ABORT_N = 15'(ABORT_CYCLES);
   localparam logic [14:0] EOCF_N = 15'(EOC_FALL_CYC);

   function automatic logic [9:0] test_code(input logic [3:0] a, input logic [9:0] s);
      unique case (a)
         ADDR_TEST_MID: test_code = CODE_MID;
         ADDR_TEST_ZERO: test_code = CODE_ZERO;
         ADDR_TEST_FULL: test_code = CODE_FULL;
         default: test_code = s;
      endcase
   endfunction : test_code

   sel_filter u_flt (
      .clk(clk),
      .srst(srst),
      .ce(ce),
      .sel_n_pin(sel_n),
      .sel_n_filt(sel_f)
   );

   assign rise = q.ck2 & ~q.ck3;
   assign fall = ~q.ck2 & q.ck3;

   always_comb begin
      d = q;
      d.ck1 = sclk;
      d.ck2 = q.ck1;
      d.ck3 = q.ck2;
      d.ad1 = addr_in;
      d.ad2 = q.ad1;
      d.sel_p = sel_f;
      if (q.since10 != 15'h7FFF) begin
         d.since10 = q.since10 + 15'h0001;
      end
      unique case (q.st)
         ST_IDLE: begin
            d.bits = 5'h00;
            // select held low: a new transfer may start immediately
            if (!sel_f) begin
               d.st = ST_SHIFT;
            end
         end
         ST_SHIFT: begin
            if (sel_f) begin
               d.st = ST_IDLE;
               d.samp = 1'b0;
            end else begin
               if (rise && q.bits < 5'h04) begin
                  d.addr_sh = {q.addr_sh[2:0], q.ad2};
               end
               if (fall) begin
                  d.bits = q.bits + 5'h01;
                  d.out_sh = {q.out_sh[8:0], 1'b0};
                  d.dout = q.out_sh[8];
                  if (q.bits + 5'h01 == ACQ_FIRST) begin
                     d.chan = q.addr_sh;
                     d.samp = 1'b1;
                  end
                  if (q.bits + 5'h01 == XFER_BITS) begin
                     d.samp = 1'b0;
                     d.st = ST_CONV;
                     d.cnt = 15'h0000;
                     d.since10 = 15'h0000;
                  end
               end
            end
         end
         ST_CONV: begin
            d.cnt = q.cnt + 15'h0001;
            if (q.cnt == EOCF_N - 15'h0001) begin
               d.eoc = 1'b0;
            end
            // extra clocks beyond ten are ignored during conversion
            if (q.sel_p && !sel_f && q.since10 < ABORT_N) begin
               d.st = ST_IDLE;
               d.eoc = 1'b1;
            end else if (q.cnt == CONV_N - 15'h0001) begin
               d.result = test_code(q.chan, sample_code);
               d.out_sh = test_code(q.chan, sample_code);
               d.dout = test_code(q.chan, sample_code) >> 9 != 10'h000;
               d.eoc = 1'b1;
               d.st = sel_f ? ST_IDLE : ST_SHIFT;
               d.bits = 5'h00;
            end
         end
         default: d.st = ST_IDLE;
      endcase
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         q <= '{st: ST_IDLE, ck1: 1'b0, ck2: 1'b0, ck3: 1'b0, ad1: 1'b0, ad2: 1'b0,
                sel_p: 1'b1, bits: 5'h00, addr_sh: 4'h0, chan: 4'h0, out_sh: RESULT_RST,
                result: RESULT_RST, cnt: 15'h0000, since10: 15'h7FFF, eoc: 1'b1,
                samp: 1'b0, dout: 1'b0};
      end else if (ce) begin
         q <= d;
      end
   end

   assign data_out = q.dout;
   assign data_oe = ~sel_f;
   assign eoc = q.eoc;
   assign channel = q.chan;
   assign sampling = q.samp;

   property p_eoc_fall;
      @(posedge clk) disable iff (srst)
      (ce && q.st == ST_SHIFT && !sel_f && fall && q.bits == 5'h09) |=> ##[0:10] !q.eoc;
   endproperty
   a_eoc_fall: assert property (p_eoc_fall) else $error("flag did not fall");

   property p_eoc_rise_msb;
      @(posedge clk) disable iff (srst)
      $rose(q.eoc) && q.st != ST_IDLE |-> q.dout == q.result[9];
   endproperty
   a_eoc_rise_msb: assert property (p_eoc_rise_msb) else $error("msb not shown");

   property p_test_mid;
      @(posedge clk) disable iff (srst)
      $rose(q.eoc) && q.chan == ADDR_TEST_MID && q.st != ST_IDLE |-> q.result == CODE_MID;
   endproperty
   a_test_mid: assert property (p_test_mid) else $error("self-test mid wrong");

   property p_test_full;
      @(posedge clk) disable iff (srst)
      $rose(q.eoc) && q.chan == ADDR_TEST_FULL && q.st != ST_IDLE |-> q.result == CODE_FULL;
   endproperty
   a_test_full: assert property (p_test_full) else $error("self-test full wrong");

   property p_sel_rise_stop;
      @(posedge clk) disable iff (srst)
      ce && q.st == ST_SHIFT && sel_f |=> q.st == ST_IDLE && !q.samp;
   endproperty
   a_sel_rise_stop: assert property (p_sel_rise_stop) else $error("shift not stopped");

   property p_idle_ignores;
      @(posedge clk) disable iff (srst)
      q.st == ST_IDLE && ce |=> q.bits == 5'h00;
   endproperty
   a_idle_ignores: assert property (p_idle_ignores) else $error("clock counted in idle");

   property p_samp_only_shift;
      @(posedge clk) disable iff (srst)
      q.samp |-> q.st == ST_SHIFT && q.bits >= ACQ_FIRST && q.bits < ACQ_LAST;
   endproperty
   a_samp_only_shift: assert property (p_samp_only_shift) else $error("bad sample window");

   property p_abort;
      @(posedge clk) disable iff (srst)
      ce && q.st == ST_CONV && q.sel_p && !sel_f && q.since10 < ABORT_N
         |=> q.st == ST_IDLE && q.eoc;
   endproperty
   a_abort: assert property (p_abort) else $error("abort not taken");

   property p_low_in_conv;
      @(posedge clk) disable iff (srst)
      q.st == ST_CONV && q.cnt > EOCF_N |-> !q.eoc;
   endproperty
   a_low_in_conv: assert property (p_low_in_conv) else $error("flag high in conversion");

   c_conv_done: cover property (@(posedge clk) disable iff (srst) $rose(q.eoc));
   c_abort: cover property (@(posedge clk) disable iff (srst)
      q.st == ST_CONV ##1 q.st == ST_IDLE && q.cnt < CONV_N - 15'h0001);
   c_held: cover property (@(posedge clk) disable iff (srst)
      q.st == ST_CONV ##1 q.st == ST_SHIFT);
endmodule : adc_seq

// >>> verification/host_model.sv
// Purpose: host serial port model for the converter sequencer
// Assumes: shift clock period of 16 system clocks
// Notes: shift clock stands low between frames
`timescale 1ns/1ns
module host_model (
   // clock
   input wire logic clk,
   // serial pins
   output logic sel_n,
   output logic sclk,
   output logic addr_in,
   input wire logic data_out,
   input wire logic eoc,
   // analog side, watched only
   input wire logic [3:0] channel,
   input wire logic sampling
);
   initial begin
      sel_n = 1'b1;
      sclk = 1'b0;
      addr_in = 1'b0;
   end
   task automatic wait_cyc(input int n);
      repeat (n) @(posedge clk);
   endtask : wait_cyc
   task automatic xfer(input logic [3:0] addr, input int nclk, input bit use_cs,
         output logic [9:0] rd, output logic [3:0] ch, output logic smp, output logic el);
      int i;
      int k;
      rd = 10'h000;
      k = 0;
      if (use_cs || sel_n) begin
         sel_n <= 1'b0;
         wait_cyc(160);
      end else begin
         while (eoc !== 1'b1 && k < 2000) begin
            @(posedge clk);
            k++;
         end
         wait_cyc(4);
      end
      for (i = 0; i < nclk; i++) begin
         // unused address bits keep moving so no stale level looks valid
         addr_in <= (i < 4) ? addr[3 - i] : ~addr_in;
         wait_cyc(8);
         if (i < 10) rd[9 - i] = data_out;
         if (i == 4) begin
            ch = channel;
            smp = sampling;
         end
         sclk <= 1'b1;
         wait_cyc(8);
         sclk <= 1'b0;
      end
      wait_cyc(16);
      el = eoc;
      if (use_cs) sel_n <= 1'b1;
   endtask : xfer
   // select low again soon after the tenth fall
   task automatic abort_conv(output logic e);
      wait_cyc(160);
      sel_n <= 1'b0;
      wait_cyc(170);
      e = eoc;
      sel_n <= 1'b1;
      wait_cyc(170);
   endtask : abort_conv
endmodule : host_model

// >>> verification/tb_top.sv
// Purpose: self-checking bench of the converter sequencer
// Assumes: shortened conversion and abort counts
// Notes: result of a frame is read during the next frame
`timescale 1ns/1ns
`define CHECK(nm, ev, gv) begin check_count++; if ((gv) !== (ev)) begin mismatches++; \
   $display("MISMATCH %s expected %0h seen %0h", nm, ev, gv); end end
module tb_top;
   import adc_seq_pkg::*;
   localparam int unsigned CONV_T = 600;
   localparam int unsigned ABORT_T = 400;
   logic clk, srst, ce, sel_n, sclk, addr_in, data_out, data_oe, eoc, sampling;
   logic [9:0] sample_code;
   logic [3:0] channel;
   logic [31:0] rng;
   logic [9:0] exp_q[$];
   logic [3:0] tst[3] = '{ADDR_TEST_MID, ADDR_TEST_ZERO, ADDR_TEST_FULL};
   int mismatches = 0;
   int check_count = 0;
   int cycles = 0;
   adc_seq #(.CONV_CYCLES(CONV_T), .ABORT_CYCLES(ABORT_T)) adc_seq_i (.clk(clk), .srst(srst),
      .ce(ce), .sel_n(sel_n), .sclk(sclk), .addr_in(addr_in), .data_out(data_out),
      .data_oe(data_oe), .eoc(eoc), .sample_code(sample_code), .channel(channel),
      .sampling(sampling));
   host_model host_model_i (.clk(clk), .sel_n(sel_n), .sclk(sclk), .addr_in(addr_in),
      .data_out(data_out), .eoc(eoc), .channel(channel), .sampling(sampling));
   function automatic logic [31:0] xs(input logic [31:0] s);
      logic [31:0] x;
      x = s ^ (s << 13);
      x = x ^ (x >> 17);
      return x ^ (x << 5);
   endfunction : xs
   function automatic logic [9:0] exp_code(input logic [3:0] a, input logic [9:0] s);
      case (a)
         ADDR_TEST_MID: return CODE_MID;
         ADDR_TEST_ZERO: return CODE_ZERO;
         ADDR_TEST_FULL: return CODE_FULL;
         default: return s;
      endcase
   endfunction : exp_code
   task automatic give_verdict();
      $display("checks %0d mismatches %0d", check_count, mismatches);
      if (mismatches == 0 && check_count > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask : give_verdict
   task automatic run_one(input logic [3:0] a, input int nclk, input bit use_cs, input bit ab);
      logic [9:0] rd, code, want;
      logic [3:0] ch;
      logic smp, el, e;
      int k;
      rng = xs(rng);
      sample_code <= rng[9:0];
      code = exp_code(a, rng[9:0]);
      host_model_i.xfer(a, nclk, use_cs, rd, ch, smp, el);
      // pop once: the macro would otherwise pop again when it reports
      if (exp_q.size() > 0) begin
         want = exp_q.pop_front();
         `CHECK("result", want, rd)
      end
      `CHECK("channel", a, ch)
      `CHECK("sampling", 1'b1, smp)
      `CHECK("samp_end", 1'b0, sampling)
      `CHECK("oe_on", 1'b1, data_oe)
      `CHECK("eoc_low", 1'b0, el)
      if (ab) begin
         host_model_i.abort_conv(e);
         `CHECK("eoc_abort", 1'b1, e)
         `CHECK("oe_off", 1'b0, data_oe)
         exp_q.delete();
      end else begin
         k = 0;
         while (eoc !== 1'b1 && k < CONV_T + 100) begin
            @(posedge clk);
            k++;
         end
         @(posedge clk);
         `CHECK("eoc_done", 1'b1, eoc)
         `CHECK("msb", code[9], data_out)
         exp_q.push_back(code);
      end
   endtask : run_one
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   always @(posedge clk) begin
      cycles++;
      if (cycles == 40000) begin
         mismatches++;
         give_verdict();
      end
   end
   initial begin
      int n;
      srst = 1'b1;
      ce = 1'b1;
      sample_code = 10'h000;
      rng = 32'h00002E4A;
      repeat (16) @(posedge clk);
      srst <= 1'b0;
      repeat (4) @(posedge clk);
      // selected frames of 10 to 16 clocks, then frames with select held low
      for (n = 0; n < 12; n++) begin
         rng = xs(rng);
         run_one((n < 3) ? tst[n] : 4'(rng % 11), (n < 8) ? 10 + (n % 7) : 10 + 6 * (n % 2),
            n < 8, 1'b0);
      end
      run_one(4'h3, 12, 1'b1, 1'b1);
      run_one(4'h5, 10, 1'b1, 1'b0);
      give_verdict();
   end
endmodule : tb_top
